// File: rtl/piv_pkg.sv
// Purpose: Constants shared by the prioritized interrupt vectoring block.
// Assumes: One processor clock; registers reached through a simple ASIC-style port.
// Notes:   Register indices follow the core's peripheral address map.
// Function
// RULE1 - Push onto full stack flags overflow, wraps.
// RULE2 - Pop from empty stack flags underflow.
// RULE3 - Touching top substack location raises fatal error.
// RULE4 - Fatal errors ORed into bit 0, cleared on pointer write.
// RULE5 - Accept, rank, mask sources; present one vector.
// RULE6 - Mask bit index equals priority; one disables.
// RULE7 - Maskable requests need disable bit zero.
// RULE8 - Core pushes return state, then acknowledges.
// RULE9 - Core zeroes code page, fetches vector.
// RULE10 - Vector: base bits 15:10, level 9:5, zeros.
// RULE11 - Handler table of 32-byte slots, 544 bytes.
// RULE12 - Sample requests each instruction, not streamed.
// RULE13 - Highest unmasked active request drives vector, request.
// RULE14 - Level code is fifteen minus priority.
// RULE15 - Non-maskable and timers edge, others level.
// RULE16 - Acknowledge clears highest pending timer edge only.
// RULE17 - Vector register shows current vector always.
// RULE18 - Masked levels never contribute a vector. NMI still contributes with mask bit 0 set.
// RULE19 - Vanished request yields no-interrupt vector.
// RULE20 - Core acknowledges only when enabled, then disables.
// RULE21 - Core sets saved return address bit 0.
// RULE22 - Return with bit 0 set re-enables interrupts.
// RULE23 - Disable bit set at reset until written zero.
// RULE24 - Timer edge stays pending; repeats merge.
`default_nettype none

package piv_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0]  ADDR_LEVEL_MASK     = 8'h08;
  localparam logic [7:0]  ADDR_CURRENT_VECTOR = 8'h0B;
  localparam logic [7:0]  ADDR_VECTOR_BASE    = 8'h03;
  localparam logic [7:0]  ADDR_CONFIGURATION  = 8'h07;
  localparam logic [7:0]  ADDR_STACK_POINTER  = 8'h01;

  localparam logic [15:0] LEVEL_MASK_RESET    = 16'h0000;
  localparam logic [5:0]  VECTOR_BASE_RESET   = 6'h00;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int          FATAL_BIT           = 0;
  localparam int          DISABLE_BIT         = 4;
  localparam int          DISABLE_STATUS_BIT  = 14;
  localparam int          REQUEST_STATUS_BIT  = 15;
  localparam int          BASE_LSB            = 10;
  localparam int          LEVEL_LSB           = 5;
  localparam int          SLOT_BYTES          = 32;
  localparam int          TABLE_BYTES         = 544;

  // ==========================================================================
  // Priorities
  // ==========================================================================
  localparam int          NUM_LEVELS          = 14;
  localparam logic [4:0]  CODE_TOP            = 5'h0F;
  localparam logic [4:0]  CODE_NONE           = 5'h10;
  localparam int          PRI_NMI             = 0;
  localparam int          PRI_EXT1            = 1;
  localparam int          PRI_PSTK_UNDER      = 2;
  localparam int          PRI_RSTK_UNDER      = 3;
  localparam int          PRI_PSTK_OVER       = 4;
  localparam int          PRI_RSTK_OVER       = 5;
  localparam int          PRI_EXT2            = 6;
  localparam int          PRI_TIMER0          = 7;
  localparam int          PRI_TIMER1          = 8;
  localparam int          PRI_TIMER2          = 9;
  localparam int          PRI_EXT3            = 10;
  localparam int          PRI_EXT4            = 11;
  localparam int          PRI_EXT5            = 12;
  localparam int          PRI_SOFTWARE        = 13;

  // Per-stack fault state.
  typedef enum logic [1:0] {
    PIV_STK_OK    = 2'b00,
    PIV_STK_ERR   = 2'b01,
    PIV_STK_FATAL = 2'b11
  } piv_stk_state_t;

endpackage

`default_nettype wire

// File: rtl/piv_top.sv
// Purpose: Ranks fourteen request levels, masks them and builds the handler vector.
// Assumes: Core supplies one-cycle acknowledge and instruction-sample strobes.
// Notes:   Stack full/empty/top-location indications come from the stack controllers.
`default_nettype none

module piv_top #(
  parameter int NUM_LEVELS = piv_pkg::NUM_LEVELS
) (
  input  wire  logic        ref_clk,
  input  wire  logic        rst_n,
  // Request sources.
  input  wire  logic        nmi_in,
  input  wire  logic [4:0]  external_request_pins,
  input  wire  logic [2:0]  timer_tick,
  input  wire  logic        software_request,
  // Stack activity, index 0 parameter stack, index 1 return stack.
  input  wire  logic [1:0]  stk_push,
  input  wire  logic [1:0]  stk_pop,
  input  wire  logic [1:0]  stk_full,
  input  wire  logic [1:0]  stk_empty,
  input  wire  logic [1:0]  stk_at_top,
  // Core handshake.
  input  wire  logic        instr_sample,
  input  wire  logic        streamed_mode,
  input  wire  logic        acknowledge_cycle,
  input  wire  logic        core_disable_set,
  input  wire  logic        return_enable,
  // Register port.
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic        reg_wr,
  input  wire  logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic        core_irq,
  output logic [15:0] core_vector,
  output logic        interrupts_disabled,
  output logic [1:0]  stk_overflow,
  output logic [1:0]  stk_underflow
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic [4:0] level_code(input logic [3:0] pri);
    level_code = piv_pkg::CODE_TOP - {1'b0, pri}; // [RULE14]
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    wr_hit = (a == target);
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [15:0] level_mask_reg;
  logic [5:0]  vector_base_reg;
  logic        disable_reg;
  logic [1:0]  fatal_reg;
  logic [2:0]  timer_prev_reg;
  logic        nmi_prev_reg;
  logic [2:0]  timer_pend_reg;
  logic [2:0]  timer_pend_next;
  logic        nmi_pend_reg;
  logic [NUM_LEVELS-1:0] sampled_reg;
  logic [15:0] vector_reg;
  logic        irq_reg;
  logic [1:0]  ovf_reg;
  logic [1:0]  unf_reg;
  logic        sp_write;
  logic        sample_en;
  logic [NUM_LEVELS-1:0] raw_req;
  logic [NUM_LEVELS-1:0] eligible;
  logic [4:0]  code_next;
  logic        any_next;

  assign sp_write  = reg_wr && wr_hit(reg_addr, piv_pkg::ADDR_STACK_POINTER);
  assign sample_en = instr_sample && !streamed_mode; // [RULE12]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_mask_reg <= piv_pkg::LEVEL_MASK_RESET;
    end else if (reg_wr && wr_hit(reg_addr, piv_pkg::ADDR_LEVEL_MASK)) begin
      level_mask_reg <= reg_wdata; // [RULE6]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_base_reg <= piv_pkg::VECTOR_BASE_RESET;
    end else if (reg_wr && wr_hit(reg_addr, piv_pkg::ADDR_VECTOR_BASE)) begin
      vector_base_reg <= reg_wdata[15:piv_pkg::BASE_LSB];
    end
  end

  // Disable bit comes up set so nothing maskable fires before software is ready.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      disable_reg <= 1'b1; // [RULE23]
    end else if (reg_wr && wr_hit(reg_addr, piv_pkg::ADDR_CONFIGURATION)) begin
      disable_reg <= reg_wdata[piv_pkg::DISABLE_BIT]; // [RULE23]
    end else if (core_disable_set) begin
      disable_reg <= 1'b1; // [RULE20]
    end else if (return_enable) begin
      disable_reg <= 1'b0; // [RULE22]
    end
  end

  // ==========================================================================
  // Stack error detection
  // ==========================================================================
  // A new fatal event in the same cycle as a pointer write wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fatal_reg <= 2'b00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if ((stk_push[s] || stk_pop[s]) && stk_at_top[s]) begin
          fatal_reg[s] <= 1'b1; // [RULE3]
        end else if (sp_write) begin
          fatal_reg[s] <= 1'b0; // [RULE4]
        end
      end
    end
  end

  // Overflow and underflow are level conditions held until the next stack access.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_reg <= 2'b00;
      unf_reg <= 2'b00;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (stk_push[s] || stk_pop[s]) begin
          ovf_reg[s] <= stk_push[s] && stk_full[s]; // [RULE1]
          unf_reg[s] <= stk_pop[s] && stk_empty[s]; // [RULE2]
        end
      end
    end
  end

  assign stk_overflow  = ovf_reg;
  assign stk_underflow = unf_reg;

  // ==========================================================================
  // Edge capture
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_prev_reg <= 3'b000;
      nmi_prev_reg   <= 1'b0;
    end else begin
      timer_prev_reg <= timer_tick;
      nmi_prev_reg   <= nmi_in;
    end
  end

  // Only the most urgent pending unmasked timer is released by an acknowledge, and none while a sampled NMI is pending.
  always_comb begin
    timer_pend_next = timer_pend_reg;
    if (acknowledge_cycle && !(nmi_pend_reg && sampled_reg[piv_pkg::PRI_NMI])) begin
      if (timer_pend_reg[0] && !level_mask_reg[piv_pkg::PRI_TIMER0]) begin
        timer_pend_next[0] = 1'b0; // [RULE16]
      end else if (timer_pend_reg[1] && !level_mask_reg[piv_pkg::PRI_TIMER1]) begin
        timer_pend_next[1] = 1'b0; // [RULE16]
      end else if (timer_pend_reg[2] && !level_mask_reg[piv_pkg::PRI_TIMER2]) begin
        timer_pend_next[2] = 1'b0; // [RULE16]
      end
    end
    timer_pend_next = timer_pend_next | (timer_tick & ~timer_prev_reg); // [RULE15] [RULE24]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pend_reg <= 3'b000;
    end else begin
      timer_pend_reg <= timer_pend_next; // [RULE24]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_in && !nmi_prev_reg) begin
      nmi_pend_reg <= 1'b1; // [RULE15]
    end else if (acknowledge_cycle && sampled_reg[piv_pkg::PRI_NMI]) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Sampling, masking and ranking
  // ==========================================================================
  always_comb begin
    raw_req = '0;
    raw_req[piv_pkg::PRI_NMI]        = nmi_pend_reg;
    raw_req[piv_pkg::PRI_EXT1]       = external_request_pins[0];
    raw_req[piv_pkg::PRI_PSTK_UNDER] = unf_reg[0];
    raw_req[piv_pkg::PRI_RSTK_UNDER] = unf_reg[1];
    raw_req[piv_pkg::PRI_PSTK_OVER]  = ovf_reg[0];
    raw_req[piv_pkg::PRI_RSTK_OVER]  = ovf_reg[1];
    raw_req[piv_pkg::PRI_EXT2]       = external_request_pins[1];
    raw_req[piv_pkg::PRI_TIMER0]     = timer_pend_reg[0];
    raw_req[piv_pkg::PRI_TIMER1]     = timer_pend_reg[1];
    raw_req[piv_pkg::PRI_TIMER2]     = timer_pend_reg[2];
    raw_req[piv_pkg::PRI_EXT3]       = external_request_pins[2];
    raw_req[piv_pkg::PRI_EXT4]       = external_request_pins[3];
    raw_req[piv_pkg::PRI_EXT5]       = external_request_pins[4];
    raw_req[piv_pkg::PRI_SOFTWARE]   = software_request; // [RULE5]
  end

  // Inputs are frozen between instruction samples so the vector is stable for the core.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_reg <= '0;
    end else if (sample_en) begin
      sampled_reg <= raw_req; // [RULE12]
    end
  end

  always_comb begin
    eligible = sampled_reg & ~level_mask_reg[NUM_LEVELS-1:0]; // [RULE6] [RULE18]
    eligible[piv_pkg::PRI_NMI] = sampled_reg[piv_pkg::PRI_NMI]; // [RULE6]
    code_next = piv_pkg::CODE_NONE; // [RULE17] [RULE19]
    any_next  = 1'b0;
    for (int p = NUM_LEVELS - 1; p >= 0; p--) begin
      if (eligible[p]) begin
        code_next = level_code(4'(p)); // [RULE13]
        any_next  = 1'b1;
      end
    end
  end

  // The vector always reflects current state, so a request gone by the
  // acknowledge yields the no-interrupt slot rather than a stale handler.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_reg <= {piv_pkg::VECTOR_BASE_RESET, piv_pkg::CODE_NONE, 5'h00};
      irq_reg    <= 1'b0;
    end else begin
      vector_reg <= {vector_base_reg, code_next, 5'h00}; // [RULE10] [RULE11]
      irq_reg    <= any_next; // [RULE13]
    end
  end

  assign core_vector         = vector_reg; // [RULE19]
  assign core_irq            = irq_reg;
  assign interrupts_disabled = disable_reg; // [RULE7]

  // ==========================================================================
  // Register read
  // ==========================================================================
  always_comb begin
    reg_rdata = 16'h0000;
    case (reg_addr)
      piv_pkg::ADDR_LEVEL_MASK: begin
        reg_rdata = {2'b00, level_mask_reg[13:1], 1'b0};
      end
      piv_pkg::ADDR_CURRENT_VECTOR: begin
        reg_rdata = vector_reg; // [RULE17]
      end
      piv_pkg::ADDR_VECTOR_BASE: begin
        reg_rdata = {vector_base_reg, 9'h000, |fatal_reg}; // [RULE4]
      end
      piv_pkg::ADDR_CONFIGURATION: begin
        reg_rdata[piv_pkg::DISABLE_STATUS_BIT] = disable_reg;
        reg_rdata[piv_pkg::REQUEST_STATUS_BIT] = irq_reg;
      end
      default: begin
        reg_rdata = 16'h0000;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: tb/piv_core_model.sv
// Purpose: Core-side partner running acknowledge cycles and handler returns.
// Assumes: It drives only on the falling clock edge.
// Notes:   ret_wait stretches the handler so slow service is exercised.
`default_nettype none
module piv_core_model (
  input  wire logic        ref_clk,
  input  wire logic        core_irq,
  input  wire logic        interrupts_disabled,
  input  wire logic [15:0] core_vector,
  input  wire logic [3:0]  ret_wait,
  output var  logic        instr_sample,
  output var  logic        acknowledge_cycle,
  output var  logic        core_disable_set,
  output var  logic        return_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Handshake
  logic [15:0] ack_q[$];
  logic [15:0] ret_addr;
  logic [7:0]  code_page;
  initial begin
    {instr_sample, acknowledge_cycle, core_disable_set, return_enable} = 4'h8;
    forever begin
      @(negedge ref_clk);
      if (core_irq === 1'b1 && interrupts_disabled === 1'b0) begin
        ret_addr = 16'h0F01;
        code_page = 8'h00;
        {acknowledge_cycle, core_disable_set} = 2'h3;
        @(posedge ref_clk);
        ack_q.push_back(core_vector);
        @(negedge ref_clk);
        {acknowledge_cycle, core_disable_set} = 2'h0;
        repeat (ret_wait) @(negedge ref_clk);
        return_enable = ret_addr[0];
        @(negedge ref_clk);
        return_enable = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/piv_top_chk.sv
// Purpose: Port checks for the interrupt vectoring block.
// Assumes: Vector and request are registered together; reads are combinational.
// Notes:   The sample-to-vector delay gets a small window, not one exact edge.
`default_nettype none
module piv_top_chk #(
  parameter int NUM_LEVELS = piv_pkg::NUM_LEVELS
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        nmi_in,
  input wire logic [1:0]  stk_push,
  input wire logic [1:0]  stk_pop,
  input wire logic [1:0]  stk_full,
  input wire logic [1:0]  stk_empty,
  input wire logic [1:0]  stk_at_top,
  input wire logic        instr_sample,
  input wire logic        streamed_mode,
  input wire logic        acknowledge_cycle,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        core_irq,
  input wire logic [15:0] core_vector,
  input wire logic        interrupts_disabled,
  input wire logic [1:0]  stk_overflow,
  input wire logic [1:0]  stk_underflow
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_nmi_rise;
    $rose(nmi_in) && instr_sample && !streamed_mode && interrupts_disabled;
  endsequence
  // Three frozen edges are needed so that a sample taken just before is flushed.
  sequence s_frozen;
    (streamed_mode && !reg_wr && !acknowledge_cycle) [*3];
  endsequence
  property p_low; core_vector[4:0] == 5'h00; endproperty
  a_low: assert property (p_low) else $error("vector low bits set");
  property p_range;
    core_vector[9:5] >= 5'(16 - NUM_LEVELS) && core_vector[9:5] <= piv_pkg::CODE_NONE;
  endproperty
  a_range: assert property (p_range) else $error("bad level code");
  property p_irq; core_irq == (core_vector[9:5] != piv_pkg::CODE_NONE); endproperty
  a_irq: assert property (p_irq) else $error("request and vector disagree");
  property p_vread; reg_addr == piv_pkg::ADDR_CURRENT_VECTOR |-> reg_rdata == core_vector;
  endproperty
  a_vread: assert property (p_vread) else $error("vector read differs");
  property p_cfg;
    reg_addr == piv_pkg::ADDR_CONFIGURATION |->
      reg_rdata[15:14] == {core_irq, interrupts_disabled} && !reg_rdata[4];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config status wrong");
  property p_en;
    reg_wr && reg_addr == piv_pkg::ADDR_CONFIGURATION && !reg_wdata[4] |=> !interrupts_disabled;
  endproperty
  a_en: assert property (p_en) else $error("enable write lost");
  property p_ovf; stk_push[0] && stk_full[0] |=> stk_overflow[0]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_unf; stk_pop[1] && stk_empty[1] |=> stk_underflow[1]; endproperty
  a_unf: assert property (p_unf) else $error("underflow missed");
  property p_fclr;
    reg_wr && reg_addr == piv_pkg::ADDR_STACK_POINTER && !(|{stk_push, stk_pop, stk_at_top})
      |=> (reg_addr != piv_pkg::ADDR_VECTOR_BASE || !reg_rdata[0]) [*3];
  endproperty
  a_fclr: assert property (p_fclr) else $error("fatal flag kept");
  property p_nmi; s_nmi_rise |-> ##[1:3] core_vector[9:5] == piv_pkg::CODE_TOP; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not vectored");
  property p_frz; s_frozen |-> $stable(core_vector); endproperty
  a_frz: assert property (p_frz) else $error("sampled while streamed");
endmodule
bind piv_top piv_top_chk #(.NUM_LEVELS(NUM_LEVELS)) u_chk (
  .ref_clk, .rst_n, .nmi_in, .stk_push, .stk_pop, .stk_full, .stk_empty, .stk_at_top,
  .instr_sample, .streamed_mode, .acknowledge_cycle, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .core_irq, .core_vector, .interrupts_disabled, .stk_overflow, .stk_underflow
);
`default_nettype wire

// File: tb/piv_top_test.sv
// Purpose: Self-checking bench for the interrupt vectoring block.
// Assumes: Inputs change on the falling edge; the core model answers requests.
// Notes:   Level sources run from a table; stack, edge and handshake cases follow.
`default_nettype none
module piv_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus
  typedef struct packed {
    logic [4:0]  ext;
    logic        sw;
    logic [15:0] mask;
    logic [3:0]  pri;
  } piv_row_t;
  localparam logic [5:0] BASE = 6'h08;
  localparam piv_row_t ROWS [10] = '{'{5'h01, 1'h0, 16'h0000, 4'h1},
    '{5'h02, 1'h0, 16'h0000, 4'h6}, '{5'h04, 1'h0, 16'h0000, 4'hA},
    '{5'h08, 1'h0, 16'h0000, 4'hB}, '{5'h10, 1'h0, 16'h0000, 4'hC},
    '{5'h00, 1'h1, 16'h0000, 4'hD}, '{5'h1F, 1'h1, 16'h0000, 4'h1},
    '{5'h1F, 1'h1, 16'h0002, 4'h6}, '{5'h1F, 1'h1, 16'h3FFE, 4'hE},
    '{5'h00, 1'h0, 16'h0000, 4'hE}};
  logic        ref_clk, rst_n, nmi_in, software_request, streamed_mode, reg_wr;
  logic        instr_sample, acknowledge_cycle, core_disable_set, return_enable;
  logic        core_irq, interrupts_disabled;
  logic [4:0]  external_request_pins;
  logic [2:0]  timer_tick;
  logic [1:0]  stk_push, stk_pop, stk_full, stk_empty, stk_at_top, stk_overflow, stk_underflow;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, core_vector;
  logic [3:0]  ret_wait;
  int          fail_count = 0;
  int          total_checks = 0;
  piv_top u_dut (
    .ref_clk, .rst_n, .nmi_in, .external_request_pins, .timer_tick, .software_request,
    .stk_push, .stk_pop, .stk_full, .stk_empty, .stk_at_top, .instr_sample, .streamed_mode,
    .acknowledge_cycle, .core_disable_set, .return_enable, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .core_irq, .core_vector, .interrupts_disabled, .stk_overflow, .stk_underflow
  );
  piv_core_model u_core (
    .ref_clk, .core_irq, .interrupts_disabled, .core_vector, .ret_wait, .instr_sample,
    .acknowledge_cycle, .core_disable_set, .return_enable
  );
  function automatic logic [4:0] code_of(input logic [3:0] pri);
    return (pri == 4'hE) ? piv_pkg::CODE_NONE : 5'(5'h0F - pri);
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    #1 chk16(reg_rdata, exp);
  endtask
  task automatic vec(input logic [4:0] code);
    chk16(core_vector, {BASE, code, 5'h00});
    rd(piv_pkg::ADDR_CURRENT_VECTOR, {BASE, code, 5'h00});
  endtask
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
  initial begin
    {rst_n, nmi_in, software_request, streamed_mode, reg_wr, ret_wait} = 9'h00C;
    {external_request_pins, timer_tick, reg_addr, reg_wdata} = 32'h00000000;
    {stk_push, stk_pop, stk_full, stk_empty, stk_at_top} = 10'h000;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    chk16(core_vector, 16'h0200);
    chk16({14'h0000, core_irq, interrupts_disabled}, 16'h0001);
    rd(piv_pkg::ADDR_CONFIGURATION, 16'h4000);
    rd(piv_pkg::ADDR_LEVEL_MASK, piv_pkg::LEVEL_MASK_RESET);
    rd(8'h0F, 16'h0000);
    $display("reset test done");
    wr(piv_pkg::ADDR_VECTOR_BASE, {BASE, 10'h000});
    foreach (ROWS[i]) begin
      @(negedge ref_clk);
      {external_request_pins, software_request} = {ROWS[i].ext, ROWS[i].sw};
      wr(piv_pkg::ADDR_LEVEL_MASK, ROWS[i].mask);
      settle();
      rd(piv_pkg::ADDR_LEVEL_MASK, ROWS[i].mask);
      vec(code_of(ROWS[i].pri));
      chk16({15'h0000, core_irq}, {15'h0000, ROWS[i].pri != 4'hE});
    end
    $display("table test done");
    @(negedge ref_clk);
    {external_request_pins, software_request, stk_full, stk_push, stk_empty, stk_pop} = 14'h5A;
    @(negedge ref_clk);
    {stk_full, stk_push, stk_empty, stk_pop} = 8'h00;
    settle();
    chk16({12'h000, stk_overflow, stk_underflow}, 16'h0006);
    vec(5'h0C);
    @(negedge ref_clk);
    {stk_push, stk_pop, stk_at_top} = 6'h1A;
    @(negedge ref_clk);
    {stk_push, stk_pop, stk_at_top} = 6'h00;
    settle();
    chk16({12'h000, stk_overflow, stk_underflow}, 16'h0000);
    vec(piv_pkg::CODE_NONE);
    rd(piv_pkg::ADDR_VECTOR_BASE, {BASE, 10'h001});
    wr(piv_pkg::ADDR_STACK_POINTER, 16'h0000);
    rd(piv_pkg::ADDR_VECTOR_BASE, {BASE, 10'h000});
    @(negedge ref_clk);
    {streamed_mode, external_request_pins} = 6'h21;
    settle();
    vec(piv_pkg::CODE_NONE);
    @(negedge ref_clk);
    streamed_mode = 1'b0;
    settle();
    vec(5'h0E);
    $display("stack and streamed tests done");
    @(negedge ref_clk);
    external_request_pins = 5'h00;
    wr(piv_pkg::ADDR_LEVEL_MASK, 16'h0001);
    for (int n = 0; n < 4; n++) begin
      @(negedge ref_clk);
      {nmi_in, timer_tick} = (n == 0) ? 4'hD : {1'b1, 3'(n == 2)};
    end
    settle();
    vec(piv_pkg::CODE_TOP);
    wr(piv_pkg::ADDR_CONFIGURATION, 16'h0000);
    for (int i = 0; i < 300 && u_core.ack_q.size() < 3; i++)
      @(negedge ref_clk);
    repeat (40) @(negedge ref_clk);
    chk16(16'(u_core.ack_q.size()), 16'h0003);
    chk16(u_core.ack_q[0], {BASE, piv_pkg::CODE_TOP, 5'h00});
    chk16(u_core.ack_q[1], {BASE, 5'h08, 5'h00});
    chk16(u_core.ack_q[2], {BASE, 5'h06, 5'h00});
    vec(piv_pkg::CODE_NONE);
    $display("acknowledge test done");
    // The non-maskable pin is dropped together with reset so its edge detector sees no false edge.
    wr(piv_pkg::ADDR_LEVEL_MASK, 16'h0010);
    @(negedge ref_clk);
    {nmi_in, rst_n} = 2'h0;
    #1 chk16({core_irq, interrupts_disabled, core_vector[13:0]}, 16'h4200);
    @(negedge ref_clk);
    rst_n = 1'b1;
    rd(piv_pkg::ADDR_LEVEL_MASK, piv_pkg::LEVEL_MASK_RESET);
    rd(piv_pkg::ADDR_CURRENT_VECTOR, 16'h0200);
    rd(piv_pkg::ADDR_CONFIGURATION, 16'h4000);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire
